// ### include/bms_cfg.svh
/*
 * timing counts and widths of the block-move sequencer.
 * assumes one core_clk cycle per cpu state.
 */
`ifndef BMS_CFG_SVH
`define BMS_CFG_SVH
`define BMS_AW          24
`define BMS_CW          16
`define BMS_OVH_STATES  8
`define BMS_BYTE_STATES 4
`define BMS_FIFO_DEPTH  16
`endif

// ### include/bms_pkg.sv
/*
 * types shared by the block-move sequencer.
 * assumes bms_cfg.svh is on the include path.
 */
`include "bms_cfg.svh"
package bms_pkg;
    typedef enum logic [2:0] {
        BMS_IDLE = 3'h0,
        BMS_OVH  = 3'h1,
        BMS_RD1  = 3'h3,
        BMS_RD2  = 3'h2,
        BMS_WR1  = 3'h6,
        BMS_WR2  = 3'h7
    } bms_state_t;

    typedef struct packed {
        logic                 req;
        logic                 we;
        logic [`BMS_AW-1:0]   addr;
        logic [7:0]           wdata;
    } bms_mreq_t;

    typedef struct packed {
        logic [`BMS_AW-1:0]   src;
        logic [`BMS_AW-1:0]   dst;
        logic [`BMS_CW-1:0]   cnt;
    } bms_regs_t;
endpackage

// ### hdl/bms_block_move.sv
/*
 * block-move sequencer with its byte fifo.
 * assumes on-chip memory answers a read in the second state of the access
 * and commits a write in the second state; the cpu waits for done.
 */
`timescale 1ns/1ns
`default_nettype none
`include "bms_cfg.svh"

module bms_fifo #(
    parameter int W = 8,
    parameter int D = `BMS_FIFO_DEPTH
) (
    input  wire logic         core_clk,
    input  wire logic         resetn,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    localparam int AB = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AB:0]   wrPtr_r;
    logic [AB:0]   rdPtr_r;

    assign inReady  = (wrPtr_r - rdPtr_r) != (AB+1)'(D);
    assign outValid = wrPtr_r != rdPtr_r;
    assign outData  = mem[rdPtr_r[AB-1:0]];

    always_ff @(posedge core_clk) begin
        if (inValid && inReady) begin
            mem[wrPtr_r[AB-1:0]] <= inData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else begin
            if (inValid && inReady) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (outValid && outReady) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
        end
    end
endmodule

// What this block does
// - each iteration copies one byte from source address to destination address
// - after each byte both pointers step up one, count steps down, until zero
// - word form loops on the full 16-bit count, otherwise same as byte form
// - zero count at start means no memory transfer, straight to next instruction
// - on-chip timing is eight states plus four states per byte moved
// - the per-byte multiplier is the count loaded before execution begins
module bms_block_move import bms_pkg::*; #(
    parameter int AW = `BMS_AW,
    parameter int CW = `BMS_CW
) (
    input  wire logic          core_clk,
    input  wire logic          resetn,
    input  wire logic          start,
    input  wire logic          wordMode,
    input  wire bms_regs_t     regsIn,
    input  wire logic [7:0]    flagsIn,
    output logic               busy,
    output logic               done,
    output bms_regs_t          regsOut,
    output logic [7:0]         flagsOut,
    output bms_mreq_t          memOut,
    input  wire logic          memRvalid,
    input  wire logic [7:0]    memRdata
);
    bms_state_t        state_r;
    bms_state_t        state_nxt;
    bms_regs_t         regs_r;
    logic              word_r;
    logic [7:0]        flags_r;
    logic [3:0]        ovhCnt_r;
    logic              done_r;
    logic              fifoInReady;
    logic              fifoOutValid;
    logic [7:0]        fifoOutData;
    logic              startTake;
    logic              loopLast;

    function automatic logic [CW-1:0] loop_count(input logic wm, input logic [CW-1:0] c);
        return wm ? c : {{(CW-8){1'b0}}, c[7:0]};
    endfunction

    assign startTake = start && (state_r == BMS_IDLE);
    // the loop ends when the active part of the count is about to reach zero
    assign loopLast  = loop_count(word_r, regs_r.cnt) == CW'(1);
    assign busy      = state_r != BMS_IDLE;
    assign done      = done_r;
    assign regsOut   = regs_r;
    assign flagsOut  = flags_r;

    bms_fifo #(.W(8), .D(`BMS_FIFO_DEPTH)) u_fifo (
        .core_clk (core_clk),
        .resetn   (resetn),
        .inValid  (state_r == BMS_RD2 && memRvalid),
        .inReady  (fifoInReady),
        .inData   (memRdata),
        .outValid (fifoOutValid),
        .outReady (state_r == BMS_WR2),
        .outData  (fifoOutData)
    );

    always_comb begin
        memOut = '0;
        unique case (state_r)
            BMS_RD1, BMS_RD2: begin
                memOut.req  = 1'b1;
                memOut.addr = regs_r.src;
            end
            BMS_WR1, BMS_WR2: begin
                memOut.req   = fifoOutValid;
                memOut.we    = 1'b1;
                memOut.addr  = regs_r.dst;
                memOut.wdata = fifoOutData;
            end
            default: ;
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            BMS_IDLE: if (startTake) state_nxt = BMS_OVH;
            BMS_OVH: begin
                if (ovhCnt_r == 4'(`BMS_OVH_STATES - 1)) begin
                    // zero count skips every memory access
                    state_nxt = (loop_count(word_r, regs_r.cnt) == '0) ? BMS_IDLE : BMS_RD1;
                end
            end
            BMS_RD1: state_nxt = BMS_RD2;
            BMS_RD2: if (memRvalid && fifoInReady) state_nxt = BMS_WR1;
            BMS_WR1: if (fifoOutValid) state_nxt = BMS_WR2;
            BMS_WR2: state_nxt = loopLast ? BMS_IDLE : BMS_RD1;
            default: state_nxt = BMS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_r <= BMS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ovhCnt_r <= '0;
        end else if (state_r == BMS_OVH) begin
            ovhCnt_r <= ovhCnt_r + 4'h1;
        end else begin
            ovhCnt_r <= '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= busy && (state_nxt == BMS_IDLE);
        end
    end

    // count and pointers are captured at start so the loop length is fixed then
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            regs_r <= '0;
            word_r <= 1'b0;
        end else if (startTake) begin
            regs_r <= regsIn;
            word_r <= wordMode;
        end else if (state_r == BMS_WR2) begin
            regs_r.src <= regs_r.src + AW'(1);
            regs_r.dst <= regs_r.dst + AW'(1);
            if (word_r) begin
                regs_r.cnt <= regs_r.cnt - CW'(1);
            end else begin
                regs_r.cnt[7:0] <= regs_r.cnt[7:0] - 8'h01;
            end
        end
    end

    // flags are only carried through, never computed here
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            flags_r <= 8'h00;
        end else if (startTake) begin
            flags_r <= flagsIn;
        end
    end

    // helper logic for the timing checks: cycles, stalls and initial count
    logic [CW+3:0] cyc_r;
    logic [CW+3:0] stall_r;
    logic [CW-1:0] n0_r;
    always_ff @(posedge core_clk) begin
        if (!resetn || startTake) begin
            cyc_r   <= '0;
            stall_r <= '0;
        end else if (busy) begin
            cyc_r <= cyc_r + 1'b1;
            if ((state_r == BMS_RD2 && !(memRvalid && fifoInReady))
                || (state_r == BMS_WR1 && !fifoOutValid)) begin
                stall_r <= stall_r + 1'b1;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            n0_r <= '0;
        end else if (startTake) begin
            n0_r <= loop_count(wordMode, regsIn.cnt);
        end
    end

    sequence s_quietOverhead;
        (busy && !memOut.req)[*8];
    endsequence

    a_zero_count_nop: assert property (@(posedge core_clk) disable iff (!resetn)
        startTake && loop_count(wordMode, regsIn.cnt) == '0
        |=> s_quietOverhead ##1 (done && !busy))
        else $error("zero count did not finish as a bare eight-state no-op");

    a_read_source: assert property (@(posedge core_clk) disable iff (!resetn)
        state_r == BMS_RD1 |-> memOut.req && !memOut.we && memOut.addr == regs_r.src
        ##1 (memOut.addr == regs_r.src && !memOut.we))
        else $error("read not addressed from source pointer");

    a_write_dest: assert property (@(posedge core_clk) disable iff (!resetn)
        state_r == BMS_WR2 |-> memOut.req && memOut.we && memOut.addr == regs_r.dst
        && memOut.wdata == fifoOutData)
        else $error("write not addressed to destination pointer");

    a_pointer_step: assert property (@(posedge core_clk) disable iff (!resetn)
        state_r == BMS_WR2 |=> regs_r.src == $past(regs_r.src) + AW'(1)
        && regs_r.dst == $past(regs_r.dst) + AW'(1)
        && regs_r.cnt[7:0] == $past(regs_r.cnt[7:0]) - 8'h01)
        else $error("pointers or count did not step after a byte");

    a_byte_high_kept: assert property (@(posedge core_clk) disable iff (!resetn)
        busy && !word_r && !startTake |=> $stable(regs_r.cnt[15:8]))
        else $error("byte form touched the high count byte");

    a_loop_ends_zero: assert property (@(posedge core_clk) disable iff (!resetn)
        done && n0_r != '0 |-> loop_count(word_r, regs_r.cnt) == '0)
        else $error("loop ended with a nonzero count");

    a_state_total: assert property (@(posedge core_clk) disable iff (!resetn)
        done |-> cyc_r == (CW+4)'(`BMS_OVH_STATES)
        + (CW+4)'(`BMS_BYTE_STATES) * (CW+4)'(n0_r) + stall_r)
        else $error("execution length differs from eight plus four per byte");

    a_flags_kept: assert property (@(posedge core_clk) disable iff (!resetn)
        busy && !startTake |=> $stable(flagsOut) && flagsOut == flags_r)
        else $error("flags changed during the block move");
endmodule

`default_nettype wire

// ### dv/bms_mem_model.sv
/*
 * on-chip memory partner for the block-move sequencer.
 * assumes memOut from the sequencer; stall delays read data.
 */
`timescale 1ns/1ns
`default_nettype none
module bms_mem_model import bms_pkg::*; (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire bms_mreq_t  memOut,
    input  wire logic [3:0] stall,
    output logic            memRvalid,
    output logic [7:0]      memRdata
);
    logic [7:0] rdCnt_r;
    logic       rdReq;
    assign rdReq = memOut.req && !memOut.we;
    always_ff @(posedge core_clk) begin
        if (!resetn || !rdReq) begin
            rdCnt_r <= 8'h00;
        end else begin
            rdCnt_r <= rdCnt_r + 8'h01;
        end
    end
    // data in the second state of a read, later when stalled
    assign memRvalid = rdReq && (rdCnt_r >= {4'h0, stall} + 8'h01);
    // toggling filler so a stale byte never passes for data
    assign memRdata = memRvalid ? (memOut.addr[7:0] ^ memOut.addr[15:8] ^ 8'h3c)
                                : (8'ha5 ^ {8{rdCnt_r[0]}});
endmodule
`default_nettype wire

// ### dv/cpu_block_move_sequencer_tb.sv
/*
 * self-checking bench of the block-move sequencer.
 * assumes bms_pkg and the memory partner are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module cpu_block_move_sequencer_tb import bms_pkg::*; ;
    typedef struct packed {
        logic [15:0] states;
        bms_regs_t   regs;
        logic [7:0]  flags;
    } bms_exp_t;
    logic       core_clk = 1'b0;
    logic       resetn   = 1'b0;
    logic       start    = 1'b0;
    logic       wordMode = 1'b0;
    bms_regs_t  regsIn   = '0;
    logic [7:0] flagsIn  = 8'h00;
    logic [3:0] stall    = 4'h0;
    logic       busy;
    logic       done;
    logic       memRvalid;
    logic [7:0] flagsOut;
    logic [7:0] memRdata;
    bms_regs_t  regsOut;
    bms_mreq_t  memOut;
    bms_exp_t   expQ[$];
    logic [31:0] wrQ[$];
    logic [15:0] busyCnt = 16'h0000;
    logic       wrPrev   = 1'b0;
    int         mismatches = 0;
    int         checked    = 0;
    int         seed       = 32'haa0f;
    int         k;

    always #5 core_clk = ~core_clk;

    bms_block_move i_bms_block_move (.core_clk(core_clk), .resetn(resetn), .start(start),
        .wordMode(wordMode), .regsIn(regsIn), .flagsIn(flagsIn), .busy(busy), .done(done),
        .regsOut(regsOut), .flagsOut(flagsOut), .memOut(memOut), .memRvalid(memRvalid),
        .memRdata(memRdata));
    bms_mem_model i_bms_mem_model (.core_clk(core_clk), .resetn(resetn), .memOut(memOut),
        .stall(stall), .memRvalid(memRvalid), .memRdata(memRdata));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic idle_wait();
        int i;
        i = 0;
        while ((busy !== 1'b0 || expQ.size() > 1) && i < 5000) begin
            @(negedge core_clk);
            i++;
        end
        if (i >= 5000) begin
            mismatches++;
            final_report();
        end
    endtask

    // start at the first idle negedge, which lands on done when back to back
    task automatic run(input logic word, input logic [15:0] cnt, input logic [3:0] st,
                       input logic [23:0] src);
        int n;
        bms_regs_t r;
        bms_exp_t e;
        logic [23:0] a;
        idle_wait();
        r = {src, src ^ 24'h80_0000, cnt};
        n = word ? int'(cnt) : int'(cnt[7:0]);
        e.states = 16'(8 + (4 + st) * n);
        e.regs = {src + 24'(n), r.dst + 24'(n), word ? 16'h0000 : {cnt[15:8], 8'h00}};
        e.flags = 8'($random(seed));
        for (int j = 0; j < n; j++) begin
            a = src + 24'(j);
            wrQ.push_back({r.dst + 24'(j), a[7:0] ^ a[15:8] ^ 8'h3c});
        end
        expQ.push_back(e);
        {wordMode, regsIn, flagsIn, stall, start} = {word, r, e.flags, st, 1'b1};
        @(negedge core_clk);
        // start held while busy with other operands must be ignored
        {wordMode, regsIn, flagsIn} = {~word, ~r, ~e.flags};
        repeat (2) @(negedge core_clk);
        start = 1'b0;
    endtask

    always @(posedge core_clk) begin
        bms_exp_t e;
        logic [31:0] w;
        logic wrNow;
        wrNow = memOut.req === 1'b1 && memOut.we === 1'b1;
        wrPrev <= wrNow;
        if (busy === 1'b1) busyCnt <= busyCnt + 16'h0001;
        if (resetn === 1'b1 && done === 1'b1) begin
            busyCnt <= 16'h0000;
            e = expQ.pop_front();
            check("states", 64'(busyCnt), 64'(e.states));
            check("regs", regsOut, e.regs);
            check("flags", 64'(flagsOut), 64'(e.flags));
        end
        if (resetn === 1'b1 && wrNow && !wrPrev) begin
            w = wrQ.size() > 0 ? wrQ.pop_front() : 32'hffff_ffff;
            check("write", {memOut.addr, memOut.wdata}, w);
        end
    end

    initial begin
        repeat (12) @(negedge core_clk);
        check("reset", 64'({busy, done, flagsOut}), 64'h0000_0000_0000_0000);
        check("resetregs", regsOut, 64'h0000_0000_0000_0000);
        check("resetmem", 64'(memOut), 64'h0000_0000_0000_0000);
        resetn = 1'b1;
        run(1'b0, 16'h3403, 4'h0, 24'h12_3456);
        run(1'b0, 16'h0100, 4'h0, 24'h00_0040);
        run(1'b1, 16'h0100, 4'h1, 24'h00_1000);
        run(1'b1, 16'h0000, 4'h0, 24'h00_2000);
        run(1'b0, 16'h00ff, 4'h0, 24'hff_ff80);
        for (k = 0; k < 8; k++) begin
            run(k[0], {k[0] ? 8'h00 : 8'($random(seed)), 4'h0, 4'($random(seed))},
                4'($random(seed)) & 4'h3, 24'($random(seed)));
        end
        idle_wait();
        repeat (3) @(negedge core_clk);
        check("pending", 64'(expQ.size() + wrQ.size()), 64'h0);
        final_report();
    end
endmodule
`default_nettype wire
